// File: hdl/spd_pkg.sv
package spd_pkg;
  // slave address preambles
  localparam logic [3:0] PRE_MEM = 4'ha;
  localparam logic [3:0] PRE_UTIL = 4'h6;
  // utility opcodes, slave address bits 3..1
  localparam logic [2:0] OP_PROT_B0 = 3'h1;
  localparam logic [2:0] OP_PROT_B1 = 3'h4;
  localparam logic [2:0] OP_PROT_B2 = 3'h5;
  localparam logic [2:0] OP_PROT_B3 = 3'h0;
  localparam logic [2:0] OP_CLEAR_ALL = 3'h3;
  localparam logic [2:0] OP_LOWER_BANK = 3'h6;
  localparam logic [2:0] OP_UPPER_BANK = 3'h7;
  // reset values and dummy byte
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic PAGE_RESET = 1'b0;
  localparam logic [3:0] PROT_RESET = 4'h0;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] DUMMY_BYTE = 8'hff;
  // bus framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] IDX_DATA = 2'h2;
  localparam logic [1:0] IDX_MAX = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_RACK = 3'b010,
    ST_TX = 3'b011,
    ST_TACK = 3'b100
  } spd_state_e;

  typedef enum logic [1:0] {
    CMD_NONE = 2'b00,
    CMD_MEM = 2'b01,
    CMD_UTIL = 2'b10
  } spd_cmd_e;

  typedef struct packed {
    logic [3:0] prot;
    logic page;
    logic busy;
  } spd_stat_s;
endpackage

// File: hdl/spd_eeprom.sv
`timescale 1ns/1ps
// Summary of operation
// - read-type slave address is acknowledged, then bytes stream from the pointer
// - master Not_acknowledge on a read byte ends the transfer; device releases the line
// - each byte placed on the bus advances the pointer while master acknowledges
// - pointer wraps within the active bank, never crossing into the other
// - protection block is bank page and address bit 7
// - protection changes only with high voltage held from start through the third byte
// - utility address bit 0: 1 queries, 0 sets or clears
// - protection query acknowledges when clear, Not_acknowledge when set
// - set on free block or clear-all acks three bytes and starts a write cycle
// - after a query address the device sends dummy bytes
// - page select acks address and dummy address, NoACKs dummy data, no cycle
// - page 0 shows the lower bank, page 1 the upper bank
// - page is 0 after power-up
// - page query acks for lower bank, NoACKs for upper, then dummy bytes
// - preamble 1010 selects memory access, 0110 selects utility commands
// - without high voltage the third byte is NoACKed and flags stay unchanged
// - pointer is 00h after power-up
module spd_eeprom
  import spd_pkg::*;
#(
  parameter int MEM_BYTES = 512
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // serial bus
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // straps and address pin level detect
  input wire logic [2:0] dev_sel,
  input wire logic high_voltage_level,
  // status
  output spd_stat_s status,
  output logic nv_write_start
);

  spd_state_e state;
  spd_cmd_e cmd;
  logic scl_q, sda_q;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic [3:0] bit_cnt;
  logic [1:0] byte_idx;
  logic [7:0] rx_sr, tx_sr, rx_byte, ptr, next_tx;
  logic rw, addr_ack, ack, drop, m_ack, hv_ok, page;
  logic [2:0] op, op_blk, rx_blk;
  logic [3:0] prot;
  logic [7:0] mem [MEM_BYTES];
  logic load_tx, decide;
  logic next_ack, next_drop, set_prot, clr_prot, page_wr, mem_we, ptr_wr;
  logic [1:0] set_blk;

  // map a utility opcode to its protection block; bit 2 flags an invalid code
  function automatic logic [2:0] blk_of(input logic [2:0] code);
    case (code)
      OP_PROT_B0: blk_of = 3'h0;
      OP_PROT_B1: blk_of = 3'h1;
      OP_PROT_B2: blk_of = 3'h2;
      OP_PROT_B3: blk_of = 3'h3;
      default: blk_of = 3'h4;
    endcase
  endfunction

  // protection block that a bank address falls in
  function automatic logic [1:0] blk_at(input logic pg, input logic [7:0] a);
    blk_at = {pg, a[7]};
  endfunction

  assign scl_rise = scl & ~scl_q;
  assign scl_fall = ~scl & scl_q;
  assign bus_start = scl & scl_q & sda_q & ~sda_in;
  assign bus_stop = scl & scl_q & ~sda_q & sda_in;
  assign rx_byte = {rx_sr[6:0], sda_in};
  assign decide = (state == ST_RX) && scl_rise && (bit_cnt == BITS_PER_BYTE - 4'h1);
  assign load_tx = scl_fall && ((state == ST_RACK && rw && byte_idx == 2'h0 && !drop) ||
                                (state == ST_TACK && m_ack));
  assign sda_out = 1'b0;
  assign op_blk = blk_of(op);
  assign rx_blk = blk_of(rx_byte[3:1]);
  assign next_tx = (cmd == CMD_MEM) ? mem[{page, ptr}] : DUMMY_BYTE;
  assign status = '{prot: prot, page: page, busy: state != ST_IDLE};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end

  // high voltage must be present at start and stay through the third byte
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hv_ok <= 1'b0;
    end else if (bus_start) begin
      hv_ok <= high_voltage_level;
    end else if (!high_voltage_level) begin
      hv_ok <= 1'b0;
    end
  end

  // answer and side effects of each received byte
  always_comb begin
    next_ack = 1'b0;
    next_drop = 1'b0;
    set_prot = 1'b0;
    clr_prot = 1'b0;
    page_wr = 1'b0;
    mem_we = 1'b0;
    ptr_wr = 1'b0;
    set_blk = op_blk[1:0];
    if (byte_idx == 2'h0) begin
      if (rx_byte[7:4] == PRE_MEM && rx_byte[3:1] == dev_sel) begin
        next_ack = 1'b1;
      end else if (rx_byte[7:4] == PRE_UTIL) begin
        set_blk = rx_blk[1:0];
        if (!rx_blk[2]) begin
          next_ack = !prot[set_blk];
        end else if (rx_byte[3:1] == OP_CLEAR_ALL && !rx_byte[0]) begin
          next_ack = 1'b1;
        end else if (rx_byte[3:1] == OP_LOWER_BANK && rx_byte[0]) begin
          next_ack = !page;
        end else if (rx_byte[3:1] == OP_LOWER_BANK || rx_byte[3:1] == OP_UPPER_BANK) begin
          next_ack = !rx_byte[0];
          next_drop = rx_byte[0];
        end else begin
          next_drop = 1'b1;
        end
      end else begin
        next_drop = 1'b1;
      end
    end else if (cmd == CMD_MEM) begin
      if (byte_idx == 2'h1) begin
        next_ack = 1'b1;
        ptr_wr = 1'b1;
      end else begin
        mem_we = !prot[blk_at(page, ptr)];
        next_ack = mem_we;
      end
    end else if (op == OP_LOWER_BANK || op == OP_UPPER_BANK) begin
      next_ack = (byte_idx == 2'h1);
      page_wr = (byte_idx == IDX_DATA);
    end else if (byte_idx == 2'h1) begin
      next_ack = addr_ack;
    end else if (byte_idx == IDX_DATA) begin
      next_ack = addr_ack && hv_ok;
      set_prot = next_ack && op != OP_CLEAR_ALL;
      clr_prot = next_ack && op == OP_CLEAR_ALL;
    end
  end

  // bus sequencing
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      byte_idx <= 2'h0;
      rx_sr <= 8'h00;
      tx_sr <= 8'h00;
      sda_oe <= 1'b0;
      ack <= 1'b0;
      drop <= 1'b0;
      m_ack <= 1'b0;
    end else if (bus_start) begin
      state <= ST_RX;
      bit_cnt <= 4'h0;
      byte_idx <= 2'h0;
      sda_oe <= 1'b0;
      drop <= 1'b0;
    end else if (bus_stop) begin
      state <= ST_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state)
        ST_RX: begin
          if (scl_rise) begin
            rx_sr <= rx_byte;
            bit_cnt <= bit_cnt + 4'h1;
          end
          if (decide) begin
            ack <= next_ack;
            drop <= next_drop;
          end
          if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
            state <= ST_RACK;
            sda_oe <= ack;
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            bit_cnt <= 4'h0;
            if (byte_idx != IDX_MAX) begin
              byte_idx <= byte_idx + 2'h1;
            end
            if (drop) begin
              state <= ST_IDLE;
              sda_oe <= 1'b0;
            end else if (load_tx) begin
              state <= ST_TX;
              tx_sr <= {next_tx[6:0], 1'b0};
              sda_oe <= ~next_tx[7];
            end else begin
              state <= ST_RX;
              sda_oe <= 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == BITS_PER_BYTE - 4'h1) begin
              state <= ST_TACK;
              sda_oe <= 1'b0;
            end else begin
              tx_sr <= {tx_sr[6:0], 1'b0};
              sda_oe <= ~tx_sr[7];
            end
          end
        end
        ST_TACK: begin
          if (scl_rise) begin
            m_ack <= ~sda_in;
          end
          if (scl_fall) begin
            bit_cnt <= 4'h0;
            if (m_ack) begin
              state <= ST_TX;
              tx_sr <= {next_tx[6:0], 1'b0};
              sda_oe <= ~next_tx[7];
            end else begin
              state <= ST_IDLE;
              sda_oe <= 1'b0;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end
  // command captured from the slave address
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmd <= CMD_NONE;
      rw <= 1'b0;
      op <= 3'h0;
      addr_ack <= 1'b0;
    end else if (decide && byte_idx == 2'h0) begin
      cmd <= (rx_byte[7:4] == PRE_MEM) ? CMD_MEM : CMD_UTIL;
      rw <= rx_byte[0];
      op <= rx_byte[3:1];
      addr_ack <= next_ack;
    end
  end

  // address pointer, wrapping inside the bank
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ptr <= PTR_RESET;
    end else if (decide && ptr_wr) begin
      ptr <= rx_byte;
    end else if ((decide && mem_we) || (load_tx && cmd == CMD_MEM)) begin
      ptr <= ptr + 8'h01;
    end
  end

  // active bank
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      page <= PAGE_RESET;
    end else if (decide && page_wr) begin
      page <= (op == OP_UPPER_BANK);
    end
  end

  // protection flags and write cycle start
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prot <= PROT_RESET;
      nv_write_start <= 1'b0;
    end else begin
      nv_write_start <= decide && (set_prot || clr_prot || mem_we);
      if (decide && set_prot) begin
        prot[set_blk] <= 1'b1;
      end else if (decide && clr_prot) begin
        prot <= PROT_RESET;
      end
    end
  end

  // storage
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < MEM_BYTES; i++) begin
        mem[i] <= ERASED_BYTE;
      end
    end else if (decide && mem_we) begin
      mem[{page, ptr}] <= rx_byte;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_read_addr_ack: assert property ((state == ST_RACK && byte_idx == 2'h0 && cmd == CMD_MEM
    && rx_sr[3:1] == dev_sel) |-> sda_oe)
    else $error("memory slave address not acknowledged");
  a_nack_release: assert property ((state == ST_TACK && scl_fall && !m_ack && !bus_start && !bus_stop)
    |=> (state == ST_IDLE && !sda_oe))
    else $error("device kept driving after master Not_acknowledge");
  a_ptr_advance: assert property ((load_tx && cmd == CMD_MEM && !bus_start && !bus_stop)
    |=> (ptr == $past(ptr) + 8'h01))
    else $error("pointer did not advance after a read byte");
  a_bank_wrap: assert property ((load_tx && cmd == CMD_MEM && ptr == 8'hff) |=> (ptr == 8'h00 && $stable(page)))
    else $error("pointer left the active bank");
  a_query_ack: assert property ((state == ST_RACK && byte_idx == 2'h0 && cmd == CMD_UTIL && rw && !op_blk[2])
    |-> (sda_oe == !prot[op_blk[1:0]]))
    else $error("protection query answered wrongly");
  a_hv_gate: assert property ($changed(prot) && prot != PROT_RESET |-> $past(hv_ok, 1))
    else $error("protection set without high voltage");
  a_page_nack: assert property ((state == ST_RACK && byte_idx == IDX_DATA && cmd == CMD_UTIL && !rw
    && (op == OP_LOWER_BANK || op == OP_UPPER_BANK)) |-> !sda_oe)
    else $error("page select data byte acknowledged");
  a_page_query: assert property ((state == ST_RACK && byte_idx == 2'h0 && cmd == CMD_UTIL && rw
    && op == OP_LOWER_BANK) |-> (sda_oe == !page))
    else $error("page query answered wrongly");
  a_write_guard: assert property ((decide && mem_we) |-> !prot[blk_at(page, ptr)])
    else $error("write into a protected block");
  a_set_cycle: assert property ((decide && set_prot) |=> (nv_write_start && prot[$past(set_blk)]))
    else $error("set protection did not start a write cycle");
endmodule

// File: verif/spd_host_model.sv
`timescale 1ns/1ps
module spd_host_model (
  // clock and wire level
  input wire logic mclk,
  input wire logic sda_wire,
  // driven bus lines
  output logic scl,
  output logic sda_pull
);
  localparam int Q = 4;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // plain or repeated start: entered with the bus idle or scl low
  task automatic start();
    sda_pull = 1'b0;
    tick(Q);
    scl = 1'b1;
    tick(Q);
    sda_pull = 1'b1;
    tick(Q);
    scl = 1'b0;
    tick(2);
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    tick(Q);
    scl = 1'b1;
    tick(Q);
    sda_pull = 1'b0;
    tick(Q);
  endtask
  // data changes only while scl is low, well after the fall
  task automatic clk_bit(input logic b, output logic s);
    sda_pull = !b;
    tick(Q);
    scl = 1'b1;
    tick(Q);
    s = sda_wire;
    scl = 1'b0;
    tick(2);
  endtask
  task automatic wr_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(v[i], s);
    end
    clk_bit(1'b1, s);
    ack = !s;
  endtask
  task automatic rd_byte(input logic mack, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, v[i]);
    end
    clk_bit(!mack, s);
  endtask
endmodule

// File: verif/tb_spd_eeprom.sv
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module tb_spd_eeprom;
  import spd_pkg::*;
  localparam logic [2:0] OPS [4] = '{OP_PROT_B0, OP_PROT_B1, OP_PROT_B2, OP_PROT_B3};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic high_voltage_level = 1'b0;
  logic [2:0] dev_sel = 3'h5;
  logic scl, sda_pull, sda_out, sda_oe, nv_write_start, a;
  logic [2:0] acks;
  logic [7:0] d;
  wire logic sda_wire;
  spd_stat_s status;
  int err_count = 0;
  int num_checks = 0;
  int nv_count = 0;
  int n;
  // open drain with pull-up
  assign sda_wire = (sda_oe ? sda_out : 1'b1) & !sda_pull;
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    if (nv_write_start === 1'b1) nv_count++;
  end
  spd_host_model host (.mclk(mclk), .sda_wire(sda_wire), .scl(scl), .sda_pull(sda_pull));
  spd_eeprom dut (.mclk(mclk), .rst(rst), .scl(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
    .dev_sel(dev_sel), .high_voltage_level(high_voltage_level), .status(status), .nv_write_start(nv_write_start));
  task automatic cmd(input logic [7:0] sa, output logic ack);
    host.start();
    host.wr_byte(sa, ack);
  endtask
  task automatic mem_wr(input logic [7:0] p, input logic [7:0] v, output logic ack);
    logic k;
    cmd({PRE_MEM, dev_sel, 1'b0}, k);
    host.wr_byte(p, k);
    host.wr_byte(v, ack);
    host.stop();
  endtask
  task automatic sel_rd(input logic [7:0] p, input logic [7:0] e[$]);
    logic k;
    logic [7:0] v;
    cmd({PRE_MEM, dev_sel, 1'b0}, k);
    host.wr_byte(p, k);
    cmd({PRE_MEM, dev_sel, 1'b1}, k);
    `CHK(k, 1'b1)
    `CHK(status.busy, 1'b1)
    foreach (e[i]) begin
      host.rd_byte(i < e.size() - 1, v);
      `CHK(v, e[i])
    end
    `CHK(sda_wire, 1'b1)
    host.stop();
  endtask
  task automatic util_set(input logic [2:0] op, output logic [2:0] r);
    cmd({PRE_UTIL, op, 1'b0}, r[2]);
    host.wr_byte(8'h00, r[1]);
    host.wr_byte(8'h00, r[0]);
    host.stop();
  endtask
  task automatic util_q(input logic [2:0] op, output logic ack, output logic [7:0] v);
    cmd({PRE_UTIL, op, 1'b1}, ack);
    host.rd_byte(1'b0, v);
    host.stop();
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    err_count++;
    print_verdict();
  end
  initial begin
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    `CHK(status.page, 1'b0)
    `CHK(status.prot, 4'h0)
    `CHK(status.busy, 1'b0)
    mem_wr(8'hfe, 8'h11, a);
    mem_wr(8'hff, 8'h22, a);
    mem_wr(8'h00, 8'h33, a);
    sel_rd(8'hfe, {8'h11, 8'h22, 8'h33});
    cmd({PRE_MEM, 3'h2, 1'b1}, a);
    `CHK(a, 1'b0)
    cmd({PRE_UTIL, 3'h2, 1'b0}, a);
    `CHK(a, 1'b0)
    host.stop();
    n = nv_count;
    util_set(OP_UPPER_BANK, acks);
    `CHK(acks, 3'b110)
    `CHK(nv_count, n)
    `CHK(status.page, 1'b1)
    util_q(OP_LOWER_BANK, a, d);
    `CHK(a, 1'b0)
    `CHK(d, DUMMY_BYTE)
    sel_rd(8'h00, {ERASED_BYTE});
    mem_wr(8'h00, 8'h44, a);
    sel_rd(8'h00, {8'h44});
    util_set(OP_LOWER_BANK, acks);
    util_q(OP_LOWER_BANK, a, d);
    `CHK(a, 1'b1)
    sel_rd(8'h00, {8'h33});
    for (int b = 0; b < 4; b++) begin
      high_voltage_level = 1'b0;
      util_set(OPS[b], acks);
      `CHK(acks, 3'b110)
      `CHK(status.prot[b], 1'b0)
      high_voltage_level = 1'b1;
      n = nv_count;
      util_set(OPS[b], acks);
      `CHK(acks, 3'b111)
      `CHK(status.prot[b], 1'b1)
      util_set(OPS[b], acks);
      `CHK(acks, 3'b000)
      `CHK(nv_count, n + 1)
      util_q(OPS[b], a, d);
      `CHK(a, 1'b0)
    end
    mem_wr(8'h10, 8'h55, a);
    sel_rd(8'h10, {ERASED_BYTE});
    util_set(OP_CLEAR_ALL, acks);
    `CHK(acks, 3'b111)
    `CHK(status.prot, 4'h0)
    util_set(OP_PROT_B2, acks);
    high_voltage_level = 1'b0;
    util_q(OP_PROT_B1, a, d);
    `CHK(a, 1'b1)
    mem_wr(8'h01, 8'h66, a);
    `CHK(a, 1'b1)
    util_set(OP_UPPER_BANK, acks);
    mem_wr(8'h81, 8'h77, a);
    `CHK(a, 1'b1)
    mem_wr(8'h01, 8'h77, a);
    `CHK(a, 1'b0)
    sel_rd(8'h01, {ERASED_BYTE});
    util_set(OP_LOWER_BANK, acks);
    sel_rd(8'h01, {8'h66});
    print_verdict();
  end
endmodule
